// ==== verilog/uart_port_pkg.sv ====
// constants shared by the dual uart host bus port and its write fifo
// assumes a single 100 mhz clock and a serial core that owns the register map
package uart_port_pkg;
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 3;
   localparam int          CHAN_N         = 2;
   localparam int          FILL_W         = 6;
   localparam int          FIFO_DEPTH     = 32;
   localparam int          WR_ENTRY_W     = 1 + ADDR_W + DATA_W;
   // positions inside the write entry {channel, address, data}
   localparam int          ENTRY_DATA_LSB = 0;
   localparam int          ENTRY_ADDR_LSB = DATA_W;
   localparam int          ENTRY_CHAN_BIT = DATA_W + ADDR_W;
   // register addresses shadowed by this port
   localparam logic [2:0]  IER_ADDR       = 3'h1;
   localparam logic [2:0]  MCR_ADDR       = 3'h4;
   localparam int          MCR_IRQ_BIT    = 3;
   localparam int          IER_W          = 4;
   localparam int          IER_RX_BIT     = 0;
   localparam int          IER_TX_BIT     = 1;
   localparam int          IER_LINE_BIT   = 2;
   localparam int          IER_MODEM_BIT  = 3;
   localparam logic [3:0]  IER_RESET      = 4'h0;
   localparam logic        MCR_IRQ_RESET  = 1'b0;
   localparam logic [7:0]  DATA_RESET     = 8'h00;
   // bit positions of the synchronised strobe vector
   localparam int          SYNC_W         = 4;
   localparam int          SYNC_SEL_A     = 0;
   localparam int          SYNC_SEL_B     = 1;
   localparam int          SYNC_RD        = 2;
   localparam int          SYNC_WR        = 3;
   localparam logic [3:0]  SYNC_RESET     = 4'hf;

   typedef enum {ST_IDLE, ST_DRAIN, ST_AWAIT, ST_DRIVE} host_state_e;
endpackage : uart_port_pkg

// ==== verilog/port_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty follow the stored count
`timescale 1ns/100ps
module port_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
   logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
   logic [CNT_W-1:0] count_q, count_d;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != CNT_W'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wr_ptr_d = push ? PTR_W'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
      rd_ptr_d = pop ? PTR_W'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
      count_d  = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
      end
   end

   // storage has no reset: it is only read behind a nonzero count
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end
endmodule : port_fifo

// ==== verilog/uart_host_port.sv ====
// host-side parallel port of a two-channel uart: strobes, data bus, irq, user output, dma ready
// assumes a serial core that drains register writes, answers read requests and reports fifo fill
`timescale 1ns/100ps
module uart_host_port
   import uart_port_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 reset_pin,
   input  wire logic                 channel_a_select_n,
   input  wire logic                 channel_b_select_n,
   input  wire logic                 read_strobe_n,
   input  wire logic                 write_strobe_n,
   input  wire logic [ADDR_W-1:0]    register_address_lines,
   input  wire logic [DATA_W-1:0]    data_in,
   output logic      [DATA_W-1:0]    data_out,
   output logic                      data_oe,
   output logic                      channel_a_irq_out,
   output logic                      channel_a_irq_oe,
   output logic                      channel_b_irq_out,
   output logic                      channel_b_irq_oe,
   output logic                      channel_a_user_output_two_n,
   output logic                      channel_b_user_output_two_n,
   output logic                      channel_a_rx_dma_ready_n,
   output logic                      channel_b_rx_dma_ready_n,
   output logic                      channel_a_tx_dma_ready_n,
   output logic                      channel_b_tx_dma_ready_n,
   output logic                      serial_enable,
   output logic                      core_wr_valid,
   input  wire logic                 core_wr_ready,
   output logic                      core_wr_chan,
   output logic      [ADDR_W-1:0]    core_wr_addr,
   output logic      [DATA_W-1:0]    core_wr_data,
   output logic                      core_rd_req,
   output logic                      core_rd_chan,
   output logic      [ADDR_W-1:0]    core_rd_addr,
   input  wire logic                 core_rd_ack,
   input  wire logic [DATA_W-1:0]    core_rd_data,
   input  wire logic [CHAN_N-1:0]    rx_error,
   input  wire logic [CHAN_N-1:0]    rx_data_avail,
   input  wire logic [CHAN_N-1:0]    tx_empty,
   input  wire logic [CHAN_N-1:0]    modem_change,
   input  wire logic [CHAN_N-1:0]    dma_mode,
   input  wire logic [CHAN_N-1:0]    rx_trigger_hit,
   input  wire logic [CHAN_N-1:0][FILL_W-1:0] rx_fill_level,
   input  wire logic [CHAN_N-1:0][FILL_W-1:0] tx_free_level
);
   function automatic logic chan_of(input logic [1:0] sel_n);
      return sel_n[0] ? 1'b1 : 1'b0;
   endfunction : chan_of
   function automatic logic any_sel(input logic [1:0] sel_n);
      return ~&sel_n;
   endfunction : any_sel
   // ---------------- synchronisers ----------------
   logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
   logic [SYNC_W-1:0] sync1_d, sync2_d, sync3_d;
   logic              rd_fall, wr_fall;
   logic [1:0]        sel_n;
   always_comb begin
      sync1_d = {write_strobe_n, read_strobe_n, channel_b_select_n, channel_a_select_n};
      sync2_d = sync1_q;
      sync3_d = sync2_q;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= SYNC_RESET;
         sync2_q <= SYNC_RESET;
         sync3_q <= SYNC_RESET;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
      end
   end
   // one pulse per falling edge, judged only on the second stage and its delayed copy
   assign rd_fall = sync3_q[SYNC_RD] & ~sync2_q[SYNC_RD];
   assign wr_fall = sync3_q[SYNC_WR] & ~sync2_q[SYNC_WR];
   assign sel_n   = {sync2_q[SYNC_SEL_B], sync2_q[SYNC_SEL_A]};
   // ---------------- write path into the fifo ----------------
   logic                  wr_valid_q, wr_valid_d;
   logic [WR_ENTRY_W-1:0] wr_entry_q, wr_entry_d;
   logic                  fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [WR_ENTRY_W-1:0] fifo_out_data;
   logic                  cwr_valid_q, cwr_valid_d;
   logic [WR_ENTRY_W-1:0] cwr_entry_q, cwr_entry_d;
   logic [CHAN_N-1:0]     mcr_irq_q, mcr_irq_d;
   logic [IER_W-1:0]      ier_q [CHAN_N];
   logic [IER_W-1:0]      ier_d [CHAN_N];
   logic                  wr_take;
   // a write edge while the holding slot is still full is dropped: the bus cannot be stalled
   assign wr_take        = wr_fall & any_sel(sel_n) & ~wr_valid_q;
   assign fifo_out_ready = ~cwr_valid_q | core_wr_ready;
   always_comb begin
      wr_valid_d  = wr_valid_q;
      wr_entry_d  = wr_entry_q;
      cwr_valid_d = cwr_valid_q;
      cwr_entry_d = cwr_entry_q;
      mcr_irq_d   = mcr_irq_q;
      ier_d       = ier_q;
      if (wr_valid_q && fifo_in_ready) begin
         wr_valid_d = 1'b0;
      end
      if (wr_take) begin
         wr_valid_d = 1'b1;
         wr_entry_d = {chan_of(sel_n), register_address_lines, data_in};
         if (register_address_lines == MCR_ADDR) begin
            mcr_irq_d[chan_of(sel_n)] = data_in[MCR_IRQ_BIT];
         end else if (register_address_lines == IER_ADDR) begin
            ier_d[chan_of(sel_n)] = data_in[IER_W-1:0];
         end
      end
      if (fifo_out_ready) begin
         cwr_valid_d = fifo_out_valid;
         cwr_entry_d = fifo_out_data;
      end
      if (reset_pin) begin
         wr_valid_d  = 1'b0;
         cwr_valid_d = 1'b0;
         mcr_irq_d   = {CHAN_N{MCR_IRQ_RESET}};
         for (int c = 0; c < CHAN_N; c++) begin
            ier_d[c] = IER_RESET;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_valid_q  <= 1'b0;
         wr_entry_q  <= '0;
         cwr_valid_q <= 1'b0;
         cwr_entry_q <= '0;
         mcr_irq_q   <= {CHAN_N{MCR_IRQ_RESET}};
         for (int c = 0; c < CHAN_N; c++) begin
            ier_q[c] <= IER_RESET;
         end
      end else begin
         wr_valid_q  <= wr_valid_d;
         wr_entry_q  <= wr_entry_d;
         cwr_valid_q <= cwr_valid_d;
         cwr_entry_q <= cwr_entry_d;
         mcr_irq_q   <= mcr_irq_d;
         ier_q       <= ier_d;
      end
   end
   port_fifo #(
      .WIDTH (WR_ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (wr_valid_q),
      .in_ready  (fifo_in_ready),
      .in_data   (wr_entry_q),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );
   assign core_wr_valid = cwr_valid_q;
   assign core_wr_chan  = cwr_entry_q[ENTRY_CHAN_BIT];
   assign core_wr_addr  = cwr_entry_q[ENTRY_ADDR_LSB +: ADDR_W];
   assign core_wr_data  = cwr_entry_q[ENTRY_DATA_LSB +: DATA_W];
   // ---------------- read sequencer ----------------
   host_state_e       state_q, state_d;
   logic              rd_req_q, rd_req_d;
   logic              rd_chan_q, rd_chan_d;
   logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
   logic [DATA_W-1:0] dout_q, dout_d;
   logic              doe_q, doe_d;
   logic              writes_idle;
   // reads wait for earlier writes so a read-back never sees stale contents
   assign writes_idle = ~wr_valid_q & ~fifo_out_valid & ~cwr_valid_q;
   always_comb begin
      state_d   = state_q;
      rd_req_d  = 1'b0;
      rd_chan_d = rd_chan_q;
      rd_addr_d = rd_addr_q;
      dout_d    = dout_q;
      doe_d     = doe_q;
      case (state_q)
         ST_IDLE: begin
            if (rd_fall && any_sel(sel_n)) begin
               rd_chan_d = chan_of(sel_n);
               rd_addr_d = register_address_lines;
               state_d   = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (sync2_q[SYNC_RD]) begin
               state_d = ST_IDLE;
            end else if (writes_idle) begin
               rd_req_d = 1'b1;
               state_d  = ST_AWAIT;
            end
         end
         ST_AWAIT: begin
            if (core_rd_ack) begin
               dout_d  = core_rd_data;
               doe_d   = ~sync2_q[SYNC_RD];
               state_d = sync2_q[SYNC_RD] ? ST_IDLE : ST_DRIVE;
            end
         end
         ST_DRIVE: begin
            if (sync2_q[SYNC_RD]) begin
               doe_d   = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (reset_pin) begin
         state_d  = ST_IDLE;
         rd_req_d = 1'b0;
         dout_d   = DATA_RESET;
         doe_d    = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q   <= ST_IDLE;
         rd_req_q  <= 1'b0;
         rd_chan_q <= 1'b0;
         rd_addr_q <= '0;
         dout_q    <= DATA_RESET;
         doe_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         rd_req_q  <= rd_req_d;
         rd_chan_q <= rd_chan_d;
         rd_addr_q <= rd_addr_d;
         dout_q    <= dout_d;
         doe_q     <= doe_d;
      end
   end

   assign core_rd_req  = rd_req_q;
   assign core_rd_chan = rd_chan_q;
   assign core_rd_addr = rd_addr_q;
   assign data_out     = dout_q;
   assign data_oe      = doe_q;
   // ---------------- per-channel outputs ----------------
   logic [CHAN_N-1:0] irq_q, irq_oe_q, op2_n_q, rxr_n_q, txr_n_q;
   logic              ser_en_q, ser_en_d;

   generate
      for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
         logic irq_d, irq_oe_d, op2_n_d, rxr_n_d, txr_n_d;
         logic cause;

         always_comb begin
            cause = (rx_error[c]      & ier_q[c][IER_LINE_BIT])
                  | (rx_data_avail[c] & ier_q[c][IER_RX_BIT])
                  | (tx_empty[c]      & ier_q[c][IER_TX_BIT])
                  | (modem_change[c]  & ier_q[c][IER_MODEM_BIT]);
            irq_d    = mcr_irq_q[c] & cause;
            irq_oe_d = mcr_irq_q[c];
            op2_n_d  = ~mcr_irq_q[c];
            if (dma_mode[c]) begin
               rxr_n_d = ~((rx_fill_level[c] != '0) & rx_trigger_hit[c]);
            end else begin
               rxr_n_d = (rx_fill_level[c] == '0);
            end
            txr_n_d = (tx_free_level[c] == '0);
            if (reset_pin) begin
               irq_d    = 1'b0;
               irq_oe_d = 1'b0;
               op2_n_d  = 1'b1;
               rxr_n_d  = 1'b1;
               txr_n_d  = 1'b1;
            end
         end

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               irq_q[c]    <= 1'b0;
               irq_oe_q[c] <= 1'b0;
               op2_n_q[c]  <= 1'b1;
               rxr_n_q[c]  <= 1'b1;
               txr_n_q[c]  <= 1'b1;
            end else begin
               irq_q[c]    <= irq_d;
               irq_oe_q[c] <= irq_oe_d;
               op2_n_q[c]  <= op2_n_d;
               rxr_n_q[c]  <= rxr_n_d;
               txr_n_q[c]  <= txr_n_d;
            end
         end
      end
   endgenerate

   always_comb begin
      ser_en_d = ~reset_pin;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ser_en_q <= 1'b0;
      end else begin
         ser_en_q <= ser_en_d;
      end
   end

   assign serial_enable               = ser_en_q;
   assign channel_a_irq_out           = irq_q[0];
   assign channel_b_irq_out           = irq_q[1];
   assign channel_a_irq_oe            = irq_oe_q[0];
   assign channel_b_irq_oe            = irq_oe_q[1];
   assign channel_a_user_output_two_n = op2_n_q[0];
   assign channel_b_user_output_two_n = op2_n_q[1];
   assign channel_a_rx_dma_ready_n    = rxr_n_q[0];
   assign channel_b_rx_dma_ready_n    = rxr_n_q[1];
   assign channel_a_tx_dma_ready_n    = txr_n_q[0];
   assign channel_b_tx_dma_ready_n    = txr_n_q[1];

   // ---------------- assertions ----------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_read_drive: assert property (state_q == ST_AWAIT && core_rd_ack && !sync2_q[SYNC_RD] && !reset_pin
      |=> data_oe && data_out == $past(core_rd_data)) else $error("read data not driven");
   a_bus_release: assert property (state_q == ST_DRIVE && sync2_q[SYNC_RD]
      |=> !data_oe) else $error("bus not released");
   a_write_capture: assert property (wr_take && !reset_pin
      |=> wr_valid_q && wr_entry_q[DATA_W-1:0] == $past(data_in)) else $error("write lost");
   a_irq_gated: assert property (channel_a_irq_out |-> $past(mcr_irq_q[0])) else $error("irq without enable");
   a_irq_cause: assert property (mcr_irq_q[0] && rx_data_avail[0] && ier_q[0][IER_RX_BIT] && !reset_pin
      |=> channel_a_irq_out) else $error("irq missing");
   a_op2_active: assert property (mcr_irq_q[0] && !reset_pin
      |=> !channel_a_user_output_two_n && channel_a_irq_oe) else $error("bit3 set not honoured");
   a_op2_idle: assert property (!mcr_irq_q[0]
      |=> channel_a_user_output_two_n && !channel_a_irq_oe) else $error("bit3 clear not honoured");
   a_reset_clear: assert property (reset_pin
      |=> !data_oe && !serial_enable && channel_b_user_output_two_n && channel_b_tx_dma_ready_n)
      else $error("reset did not clear");
   a_rx_ready: assert property (!dma_mode[0] && rx_fill_level[0] != '0 && !reset_pin
      |=> !channel_a_rx_dma_ready_n) else $error("rx ready late");
   a_rx_empty: assert property (rx_fill_level[1] == '0 |=> channel_b_rx_dma_ready_n)
      else $error("rx ready while empty");
   a_tx_full: assert property (tx_free_level[0] == '0 |=> channel_a_tx_dma_ready_n)
      else $error("tx ready while full");
   a_read_once: assert property (core_rd_req |=> !core_rd_req [*2]) else $error("read issued twice");

   c_write: cover property (wr_take ##[1:40] core_wr_valid && core_wr_ready);
   c_read: cover property (core_rd_req ##[1:20] data_oe);
   c_irq: cover property (channel_b_irq_out);
   c_fifo_full: cover property (!fifo_in_ready);
endmodule : uart_host_port

// ==== testbench/core_model.sv ====
// behavioural serial core facing the host port: accepts register writes, answers read requests
// assumes read chan/addr are held from the request until the answer
`timescale 1ns/100ps
module core_model (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       stall,
   input  wire logic       rd_slow,
   output logic            core_wr_ready,
   input  wire logic       core_rd_req,
   input  wire logic       core_rd_chan,
   input  wire logic [2:0] core_rd_addr,
   output logic            core_rd_ack,
   output logic      [7:0] core_rd_data
);
   logic       pend;
   logic [2:0] wait_q;

   // a stalled core pushes back on the write stream
   assign core_wr_ready = ~stall;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pend         <= 1'b0;
         wait_q       <= 3'h0;
         core_rd_ack  <= 1'b0;
         core_rd_data <= 8'h00;
      end else begin
         core_rd_ack  <= 1'b0;
         // outside the answer the data is inverted every cycle, so it holds the last byte only every other cycle
         core_rd_data <= ~core_rd_data;
         if (core_rd_req) begin
            pend   <= 1'b1;
            wait_q <= rd_slow ? 3'h4 : 3'h0;
         end else if (pend && wait_q == 3'h0) begin
            core_rd_ack  <= 1'b1;
            core_rd_data <= {4'ha, core_rd_chan, core_rd_addr};
            pend         <= 1'b0;
         end else if (pend) begin
            wait_q <= wait_q - 3'h1;
         end
      end
   end
endmodule : core_model

// ==== testbench/tb.sv ====
// self-checking bench for the dual uart host bus port
// assumes core_model as the serial core; host bus driven at the falling edge
`timescale 1ns/100ps
module tb
   import uart_port_pkg::*;
;
   logic clock, rstn, reset_pin, channel_a_select_n, channel_b_select_n, read_strobe_n, write_strobe_n;
   logic [ADDR_W-1:0] register_address_lines, core_wr_addr, core_rd_addr;
   logic [DATA_W-1:0] data_in, data_out, core_wr_data, core_rd_data;
   logic data_oe, channel_a_irq_out, channel_a_irq_oe, channel_b_irq_out, channel_b_irq_oe, serial_enable;
   logic channel_a_user_output_two_n, channel_b_user_output_two_n, stall, rd_slow;
   logic channel_a_rx_dma_ready_n, channel_b_rx_dma_ready_n, channel_a_tx_dma_ready_n, channel_b_tx_dma_ready_n;
   logic core_wr_valid, core_wr_ready, core_wr_chan, core_rd_req, core_rd_chan, core_rd_ack;
   logic [CHAN_N-1:0] rx_error, rx_data_avail, tx_empty, modem_change, dma_mode, rx_trigger_hit;
   logic [CHAN_N-1:0][FILL_W-1:0] rx_fill_level, tx_free_level;
   logic [11:0] rx_q[$];
   int          err_count, comparisons;

   uart_host_port uart_host_port_inst (.clock, .rstn, .reset_pin, .channel_a_select_n, .channel_b_select_n,
      .read_strobe_n, .write_strobe_n, .register_address_lines, .data_in, .data_out, .data_oe,
      .channel_a_irq_out, .channel_a_irq_oe, .channel_b_irq_out, .channel_b_irq_oe,
      .channel_a_user_output_two_n, .channel_b_user_output_two_n, .channel_a_rx_dma_ready_n,
      .channel_b_rx_dma_ready_n, .channel_a_tx_dma_ready_n, .channel_b_tx_dma_ready_n, .serial_enable,
      .core_wr_valid, .core_wr_ready, .core_wr_chan, .core_wr_addr, .core_wr_data, .core_rd_req,
      .core_rd_chan, .core_rd_addr, .core_rd_ack, .core_rd_data, .rx_error, .rx_data_avail, .tx_empty,
      .modem_change, .dma_mode, .rx_trigger_hit, .rx_fill_level, .tx_free_level);
   core_model core_model_inst (.clock, .rstn, .stall, .rd_slow, .core_wr_ready, .core_rd_req,
      .core_rd_chan, .core_rd_addr, .core_rd_ack, .core_rd_data);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (core_wr_valid && core_wr_ready) rx_q.push_back({core_wr_chan, core_wr_addr, core_wr_data});
   end

   task automatic conclude();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic settle();
      repeat (2) @(negedge clock);
   endtask : settle

   task automatic wait_oe(input logic lvl);
      for (int n = 0; n < 30 && data_oe !== lvl; n++) @(negedge clock);
      if (data_oe !== lvl) begin
         err_count++;
         conclude();
      end
   endtask : wait_oe

   // strobe kept low four cycles so the synchronised fall is seen with address and data stable
   task automatic hwrite(input logic [1:0] sn, input logic [2:0] a, input logic [7:0] d);
      @(negedge clock);
      {channel_b_select_n, channel_a_select_n} = sn;
      register_address_lines = a;
      data_in = d;
      write_strobe_n = 1'b0;
      repeat (4) @(negedge clock);
      write_strobe_n = 1'b1;
      repeat (4) @(negedge clock);
      {channel_b_select_n, channel_a_select_n} = 2'b11;
      data_in = ~d;
   endtask : hwrite

   task automatic expect_wr(input logic [11:0] e);
      check(12'(rx_q.size()), 12'h1);
      if (rx_q.size() > 0) check(rx_q.pop_front(), e);
   endtask : expect_wr

   task automatic hread(input logic ch, input logic [2:0] a);
      @(negedge clock);
      {channel_b_select_n, channel_a_select_n} = ch ? 2'b01 : 2'b10;
      register_address_lines = a;
      read_strobe_n = 1'b0;
      wait_oe(1'b1);
      check(data_out, {4'ha, ch, a});
      read_strobe_n = 1'b1;
      {channel_b_select_n, channel_a_select_n} = 2'b11;
      wait_oe(1'b0);
      check(data_oe, 1'b0);
   endtask : hread

   task automatic causes(input logic [3:0] c);
      {modem_change[0], rx_error[0], tx_empty[0], rx_data_avail[0]} = c;
      settle();
   endtask : causes

   function automatic logic [1:0] ready_pair(input int ch);
      return ch ? {channel_b_rx_dma_ready_n, channel_b_tx_dma_ready_n}
                : {channel_a_rx_dma_ready_n, channel_a_tx_dma_ready_n};
   endfunction : ready_pair

   task automatic irq_test();
      hwrite(2'b10, MCR_ADDR, 8'h08);
      check({channel_a_user_output_two_n, channel_a_irq_oe, channel_b_user_output_two_n}, 3'b011);
      for (int i = 0; i < 4; i++) begin
         hwrite(2'b10, IER_ADDR, 8'(1 << i));
         causes(~4'(1 << i));
         check(channel_a_irq_out, 1'b0);
         causes(4'(1 << i));
         check(channel_a_irq_out, 1'b1);
      end
      hwrite(2'b10, MCR_ADDR, 8'h00);
      check({channel_a_user_output_two_n, channel_a_irq_oe, channel_a_irq_out, channel_b_irq_oe}, 4'b1000);
      causes(4'h0);
      hwrite(2'b01, MCR_ADDR, 8'h08);
      hwrite(2'b01, IER_ADDR, 8'h01);
      rx_data_avail[1] = 1'b1;
      settle();
      check({channel_b_irq_out, channel_b_irq_oe, channel_b_user_output_two_n}, 3'b110);
      hwrite(2'b01, MCR_ADDR, 8'h00);
      check({channel_b_irq_out, channel_b_irq_oe, channel_b_user_output_two_n}, 3'b001);
      rx_data_avail[1] = 1'b0;
      rx_q.delete();
   endtask : irq_test

   task automatic dma_test(input int ch);
      dma_mode[ch] = 1'b0;
      rx_fill_level[ch] = 6'h00;
      tx_free_level[ch] = 6'h00;
      settle();
      check(ready_pair(ch), 2'b11);
      rx_fill_level[ch] = 6'h01;
      tx_free_level[ch] = 6'h01;
      settle();
      check(ready_pair(ch), 2'b00);
      dma_mode[ch] = 1'b1;
      rx_fill_level[ch] = 6'h20;
      tx_free_level[ch] = 6'h00;
      settle();
      check(ready_pair(ch), 2'b11);
      rx_trigger_hit[ch] = 1'b1;
      tx_free_level[ch] = 6'h01;
      settle();
      check(ready_pair(ch), 2'b00);
   endtask : dma_test

   task automatic fifo_test();
      rx_q.delete();
      stall = 1'b1;
      for (int i = 0; i < 36; i++) hwrite(2'b10, 3'h0, 8'(i));
      stall = 1'b0;
      repeat (60) @(negedge clock);
      check(12'(rx_q.size()), 12'(FIFO_DEPTH + 2));
      for (int i = 0; i < FIFO_DEPTH + 2 && i < rx_q.size(); i++) check(rx_q[i], {4'h0, 8'(i)});
   endtask : fifo_test

   initial begin
      {rstn, reset_pin, stall, rd_slow} = 4'b0000;
      {channel_a_select_n, channel_b_select_n, read_strobe_n, write_strobe_n} = 4'hf;
      register_address_lines = 3'h0;
      data_in = 8'h00;
      {rx_error, rx_data_avail, tx_empty, modem_change, dma_mode, rx_trigger_hit} = 12'h000;
      rx_fill_level = 12'h000;
      tx_free_level = 12'h041;
      err_count = 0;
      comparisons = 0;
      repeat (12) @(negedge clock);
      check({data_oe, channel_a_user_output_two_n, channel_a_irq_oe, serial_enable}, 4'b0100);
      rstn = 1'b1;
      settle();
      check(serial_enable, 1'b1);
      hwrite(2'b10, 3'h0, 8'h01);
      expect_wr({4'h0, 8'h01});
      hwrite(2'b01, 3'h7, 8'h80);
      expect_wr({4'hf, 8'h80});
      hwrite(2'b00, 3'h2, 8'h5a);
      expect_wr({4'h2, 8'h5a});
      hwrite(2'b11, 3'h3, 8'hff);
      check(12'(rx_q.size()), 12'h0);
      hread(1'b0, 3'h3);
      rd_slow = 1'b1;
      hread(1'b1, 3'h6);
      irq_test();
      dma_test(0);
      dma_test(1);
      hwrite(2'b10, MCR_ADDR, 8'h08);
      reset_pin = 1'b1;
      settle();
      check({channel_a_user_output_two_n, channel_a_irq_oe, serial_enable, data_oe, ready_pair(0)}, 6'h23);
      reset_pin = 1'b0;
      settle();
      check({serial_enable, channel_a_user_output_two_n}, 2'b11);
      fifo_test();
      conclude();
   end
endmodule : tb
